// [dv/hi_mem_model.sv]
// higher memory and stack memory model behind both memory ports
// assumes one request at a time on each port, answered a cycle later
`timescale 1ns/1ps
module hi_mem_model (
  input  wire logic        mclk,
  input  wire logic        ext_req_q,
  input  wire logic [15:0] ext_addr_q,
  input  wire logic        stk_req_q,
  input  wire logic        stk_we_q,
  input  wire logic [15:0] stk_addr_q,
  input  wire logic [31:0] stk_wdata_q,
  output logic             ext_ack,
  output logic [15:0]      ext_rdata,
  output logic             stk_ack,
  output logic [31:0]      stk_rdata
);
  logic [31:0] mem [256];
  initial begin
    ext_ack = 1'b0;
    stk_ack = 1'b0;
    ext_rdata = 16'h0000;
    stk_rdata = 32'h0000_0000;
  end
  // ack next cycle; idle data flips so stale values never match
  always @(posedge mclk) begin
    ext_ack <= ext_req_q;
    ext_rdata <= ext_req_q ? (ext_addr_q ^ 16'h5a5a) : ~ext_rdata;
    stk_ack <= stk_req_q;
    stk_rdata <= (stk_req_q && !stk_we_q) ? mem[stk_addr_q[7:0]] : ~stk_rdata;
    if (stk_req_q && stk_we_q)
      mem[stk_addr_q[7:0]] <= stk_wdata_q;
  end
endmodule

// [dv/register_file_windowing_stack_tb.sv]
// self-checking bench: register accesses, windows and stack operations
// assumes the memory model answers both memory ports of the block
`timescale 1ns/1ps
module register_file_windowing_stack_tb;
  logic        mclk, rst, acc_valid, acc_write, acc_word, mode_1m, call_req, ret_req;
  logic        push_all_instruction, pop_all_instruction, ext_req_q, ext_we_q, ext_word_q;
  logic        acc_done_q, acc_busy_q, hold_protocol_enable, stk_busy_q, stk_req_q;
  logic        stk_we_q, stk_wide_q, ext_ack, stk_ack, pc_valid_q;
  logic [7:0]  acc_addr;
  logic [15:0] acc_wdata, acc_rdata_q, ext_addr_q, ext_wdata_q, ext_rdata, stk_addr_q;
  logic [15:0] last_ext, last_stk;
  logic [17:0] last_ew;
  logic [1:0]  last_sctl;
  int          busy_cnt = 0;
  logic [19:0] pc_in, pc_out_q, last_pc;
  logic [31:0] stk_wdata_q, stk_rdata, last_wd;
  int          num_errors = 0, num_checks = 0, cycles = 0, ext_cnt = 0;
  register_file_windowing_stack u_register_file_windowing_stack (.*);
  hi_mem_model u_hi_mem_model (.*);
  always #2 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register access, bounded wait for completion
  task automatic acc(input logic w, input logic wd, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_word <= wd;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge mclk);
    acc_valid <= 1'b0;
    #1;
    while (acc_done_q !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 20) num_errors++;
  endtask
  // one stack op: 1 call, 2 return, 4 push all, 8 pop all
  task automatic stk(input logic [3:0] op, input logic [19:0] pc);
    int n;
    n = 0;
    @(posedge mclk);
    {pop_all_instruction, push_all_instruction, ret_req, call_req} <= op;
    pc_in <= pc;
    @(posedge mclk);
    {pop_all_instruction, push_all_instruction, ret_req, call_req} <= 4'h0;
    #1;
    while (stk_busy_q !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 20) num_errors++;
    // let the captured pc settle before the caller compares it
    @(posedge mclk);
    #1;
  endtask
  task automatic summarize();
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // capture forwarded and stack traffic, cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (acc_busy_q)
      busy_cnt++;
    if (ext_req_q) begin
      last_ext <= ext_addr_q;
      last_ew <= {ext_we_q, ext_word_q, ext_wdata_q};
      ext_cnt++;
    end
    if (stk_req_q) begin
      last_stk <= stk_addr_q;
      last_sctl <= {stk_we_q, stk_wide_q};
      last_wd <= stk_wdata_q;
    end
    if (pc_valid_q)
      last_pc <= pc_out_q;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {acc_valid, acc_write, acc_word, mode_1m, call_req, ret_req} = 6'h00;
    {push_all_instruction, pop_all_instruction} = 2'h0;
    acc_addr = 8'h00;
    acc_wdata = 16'h0000;
    pc_in = 20'h00000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    acc(0, 1, 8'h00, 0); chk(acc_rdata_q, 16'h0000);
    acc(0, 1, 8'h02, 0); chk(acc_rdata_q, 16'hffff);
    acc(1, 0, 8'h3f, 16'h00a5); acc(0, 0, 8'h3f, 0); chk(acc_rdata_q[7:0], 8'ha5);
    chk(ext_cnt, 0);
    acc(1, 0, 8'h14, 16'h0090); chk(hold_protocol_enable, 1'b1);
    acc(0, 0, 8'h80, 0); chk(last_ext, 16'h0100);
    chk(acc_rdata_q[7:0], 8'h5a);
    acc(1, 0, 8'h15, 16'h0020); acc(0, 0, 8'h40, 0); chk(last_ext, 16'h0100);
    acc(0, 0, 8'h3f, 0); chk(acc_rdata_q[7:0], 8'ha5);
    chk(ext_cnt, 2);
    acc(1, 0, 8'h14, 16'h0041); chk(hold_protocol_enable, 1'b0);
    acc(0, 0, 8'he0, 0); chk(last_ext, 16'h0120);
    acc(1, 1, 8'he3, 16'hbeef); chk(last_ext, 16'h0122);
    chk(last_ew, 18'h3beef);
    acc(1, 1, 8'h0c, 16'h1234); acc(1, 0, 8'h0c, 16'h00ff); acc(0, 1, 8'h0c, 0);
    chk(acc_rdata_q, 16'h1234);
    acc(1, 1, 8'h18, 16'h0100);
    stk(4'h1, 20'h01234); chk(last_stk, 16'h00fe);
    chk(last_wd[19:0], 20'h01234);
    acc(0, 1, 8'h18, 0); chk(acc_rdata_q, 16'h00fe);
    stk(4'h2, 20'h0); chk(last_pc, 20'h01234);
    chk(last_sctl, 2'b00);
    acc(0, 1, 8'h18, 0); chk(acc_rdata_q, 16'h0100);
    @(posedge mclk);
    mode_1m <= 1'b1;
    stk(4'h1, 20'habcde); chk(last_stk, 16'h00fc);
    chk(last_sctl, 2'b11);
    stk(4'h2, 20'h0); chk(last_pc, 20'habcde);
    stk(4'h4, 20'h0); acc(1, 0, 8'h14, 16'h0000); stk(4'h8, 20'h0);
    acc(0, 0, 8'h14, 0); chk(acc_rdata_q[7:0], 8'h41);
    chk(busy_cnt, 8);
    summarize();
  end
endmodule

// [src/register_file_windowing_stack.sv]
// lower register file: cpu special registers, stack pointer, ram and two windows
// assumes the cpu direct-address datapath issues one access at a time on acc_valid
// and that the higher-memory port answers each forwarded access with ext_ack
`timescale 1ns/1ps
module register_file_windowing_stack #(
  parameter bit HAS_MAC = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_word,
  input  wire logic [7:0]  acc_addr,
  input  wire logic [15:0] acc_wdata,
  output logic [15:0]      acc_rdata_q,
  output logic             acc_done_q,
  output logic             acc_busy_q,
  output logic             ext_req_q,
  output logic             ext_we_q,
  output logic             ext_word_q,
  output logic [15:0]      ext_addr_q,
  output logic [15:0]      ext_wdata_q,
  input  wire logic        ext_ack,
  input  wire logic [15:0] ext_rdata,
  output logic             hold_protocol_enable,
  input  wire logic        mode_1m,
  input  wire logic        call_req,
  input  wire logic [19:0] pc_in,
  input  wire logic        ret_req,
  input  wire logic        push_all_instruction,
  input  wire logic        pop_all_instruction,
  output logic             stk_busy_q,
  output logic             stk_req_q,
  output logic             stk_we_q,
  output logic             stk_wide_q,
  output logic [15:0]      stk_addr_q,
  output logic [31:0]      stk_wdata_q,
  input  wire logic        stk_ack,
  input  wire logic [31:0] stk_rdata,
  output logic [19:0]      pc_out_q,
  output logic             pc_valid_q
);
  initial begin
    if (HAS_MAC !== 1'b0 && HAS_MAC !== 1'b1) $error("HAS_MAC must be 0 or 1");
  end

  rfw_pkg::acc_state_t st_q, st_d;
  logic [7:0]  mem_q [0:255];
  logic [7:0]  mem_d [0:255];
  logic [15:0] sp_q, sp_wdata, restore_word, push_word;
  logic [1:0]  sp_we;
  logic        restore_valid;
  logic        pri_on, sec_on_raw, sec_on, pri_hit, sec_hit, take;
  logic [7:0]  pri_size, sec_size, pri_lo, sec_lo, a0, a1;
  logic [15:0] pri_base, sec_base, win_addr;
  logic [15:0] rdata_d, ewd_d, eaddr_d;
  logic        done_d, ereq_d, ewe_d, eword_d;

  // true when addr lies in an active window between lo and top
  function automatic logic win_hit(input logic [7:0] a, input logic on,
                                   input logic [7:0] lo, input logic [7:0] top);
    win_hit = on && a >= lo && a <= top;
  endfunction

  // true for locations that hold software-writable storage
  function automatic logic is_rw(input logic [7:0] a);
    is_rw = 1'b1;
    if (a < rfw_pkg::ADR_FIRST_RW) is_rw = 1'b0;
    else if (a > rfw_pkg::ADR_INT_FLL && a < rfw_pkg::ADR_ACCUMULATOR_STATUS) is_rw = 1'b0;
    else if (a >= rfw_pkg::ADR_ACCUMULATOR_STATUS && a < rfw_pkg::ADR_INT_FLH) is_rw = HAS_MAC
        && a < rfw_pkg::ADR_ACC_W1 + 8'h02;
    else if (a == rfw_pkg::ADR_WSEL_S) is_rw = HAS_MAC;
    else if (a > rfw_pkg::ADR_WSEL_S && a <= rfw_pkg::ADR_SFR_LAST) is_rw = 1'b0;
    else if (a == rfw_pkg::ADR_SP_LO || a == rfw_pkg::ADR_SP_HI) is_rw = 1'b0;
  endfunction

  // special register decode
  // byte read view of the local file
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [15:0] sp);
    if (a == rfw_pkg::ADR_ONES || a == rfw_pkg::ADR_ONES + 8'h01) rd_byte = rfw_pkg::BYTE_ONES;
    else if (a == rfw_pkg::ADR_SP_LO) rd_byte = sp[7:0];
    else if (a == rfw_pkg::ADR_SP_HI) rd_byte = sp[15:8];
    else if (is_rw(a)) rd_byte = mem_q[a];
    else rd_byte = 8'h00;
  endfunction

  window_decode #(.ALLOW_128(1'b1)) u_pri (
    .code     (mem_q[rfw_pkg::ADR_WSEL_P][6:0]),
    .win_on   (pri_on),
    .win_size (pri_size),
    .win_base (pri_base)
  );

  // secondary window decode, no 128-byte size
  window_decode #(.ALLOW_128(1'b0)) u_sec (
    .code     (mem_q[rfw_pkg::ADR_WSEL_S][6:0]),
    .win_on   (sec_on_raw),
    .win_size (sec_size),
    .win_base (sec_base)
  );

  stack_unit u_stack (
    .mclk            (mclk),
    .rst             (rst),
    .mode_1m         (mode_1m),
    .call_req        (call_req),
    .pc_in           (pc_in),
    .ret_req         (ret_req),
    .push_all_req    (push_all_instruction),
    .pop_all_req     (pop_all_instruction),
    .push_word       (push_word),
    .sp_we           (sp_we),
    .sp_wdata        (sp_wdata),
    .stk_ack         (stk_ack),
    .stk_rdata       (stk_rdata),
    .sp_q            (sp_q),
    .stk_busy_q      (stk_busy_q),
    .stk_req_q       (stk_req_q),
    .stk_we_q        (stk_we_q),
    .stk_wide_q      (stk_wide_q),
    .stk_addr_q      (stk_addr_q),
    .stk_wdata_q     (stk_wdata_q),
    .pc_out_q        (pc_out_q),
    .pc_valid_q      (pc_valid_q),
    .restore_valid_q (restore_valid),
    .restore_word_q  (restore_word)
  );

  // window placement: primary at the top, secondary just below 80h
  // secondary only with the mac unit
  assign sec_on  = HAS_MAC && sec_on_raw;
  assign pri_lo  = 8'h00 - pri_size;
  assign sec_lo  = rfw_pkg::SEC_END - sec_size;
  assign pri_hit = win_hit(acc_addr, pri_on, pri_lo, rfw_pkg::PRI_TOP);
  assign sec_hit = win_hit(acc_addr, sec_on, sec_lo, rfw_pkg::SEC_TOP);
  assign win_addr = pri_hit ? pri_base + 16'(acc_addr - pri_lo)
                            : sec_base + 16'(acc_addr - sec_lo);
  assign take      = acc_valid && st_q == rfw_pkg::ACC_IDLE;
  assign a0        = {acc_addr[7:1], 1'b0};
  assign a1        = {acc_addr[7:1], 1'b1};
  assign push_word = {mem_q[rfw_pkg::ADR_INT_ENH], mem_q[rfw_pkg::ADR_WSEL_P]};
  // hold bit goes to the bus-hold logic and into the push-all word
  assign hold_protocol_enable = mem_q[rfw_pkg::ADR_WSEL_P][rfw_pkg::HOLD_BIT];

  // access sequencer and local file next values
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 256; i++) mem_d[i] = mem_q[i];
    rdata_d = acc_rdata_q;  done_d = 1'b0;  ereq_d = 1'b0;
    ewe_d = ext_we_q;  eword_d = ext_word_q;  eaddr_d = ext_addr_q;  ewd_d = ext_wdata_q;
    sp_we = 2'b00;  sp_wdata = acc_wdata;
    case (st_q)
      rfw_pkg::ACC_IDLE: begin
        if (take && (pri_hit || sec_hit)) begin
          ereq_d = 1'b1;  ewe_d = acc_write;  eword_d = acc_word;
          eaddr_d = acc_word ? {win_addr[15:1], 1'b0} : win_addr;
          ewd_d = acc_wdata;
          st_d = rfw_pkg::ACC_WAIT;
        end else if (take) begin
          done_d = 1'b1;
          rdata_d = acc_word ? {rd_byte(a1, sp_q), rd_byte(a0, sp_q)}
                             : {8'h00, rd_byte(acc_addr, sp_q)};
          // byte access to accumulator words is refused
          if (!acc_word && (a0 == rfw_pkg::ADR_ACC_W0 || a0 == rfw_pkg::ADR_ACC_W1)) begin
            rdata_d = 16'h0000;
          end else if (acc_write) begin
            if (acc_word) begin
              if (is_rw(a0)) mem_d[a0] = acc_wdata[7:0];
              if (is_rw(a1)) mem_d[a1] = acc_wdata[15:8];
              if (a0 == rfw_pkg::ADR_SP_LO) sp_we = 2'b11;
            end else begin
              if (is_rw(acc_addr)) mem_d[acc_addr] = acc_wdata[7:0];
              if (acc_addr == rfw_pkg::ADR_SP_LO) sp_we = 2'b01;
              if (acc_addr == rfw_pkg::ADR_SP_HI) begin
                sp_we = 2'b10;
                sp_wdata = {acc_wdata[7:0], acc_wdata[7:0]};
              end
            end
          end
        end
      end
      rfw_pkg::ACC_WAIT: begin
        if (ext_ack) begin
          done_d  = 1'b1;
          rdata_d = ext_word_q ? ext_rdata : {8'h00, ext_rdata[7:0]};
          st_d    = rfw_pkg::ACC_IDLE;
        end
      end
      default: st_d = rfw_pkg::ACC_IDLE;
    endcase
    // pop all restores the select, over a cpu write
    if (restore_valid) begin
      mem_d[rfw_pkg::ADR_INT_ENH] = restore_word[15:8];
      mem_d[rfw_pkg::ADR_WSEL_P]  = restore_word[7:0];
    end
  end

  // local file and access registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= rfw_pkg::ACC_IDLE;
      for (int i = 0; i < 256; i++) mem_q[i] <= 8'h00;
      mem_q[rfw_pkg::ADR_WSEL_P] <= rfw_pkg::WSEL_RESET;
      acc_rdata_q <= 16'h0000;  acc_done_q <= 1'b0;  acc_busy_q <= 1'b0;
      ext_req_q <= 1'b0;  ext_we_q <= 1'b0;  ext_word_q <= 1'b0;
      ext_addr_q <= 16'h0000;  ext_wdata_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      for (int i = 0; i < 256; i++) mem_q[i] <= mem_d[i];
      acc_rdata_q <= rdata_d;  acc_done_q <= done_d;
      acc_busy_q <= (st_d == rfw_pkg::ACC_WAIT);
      ext_req_q <= ereq_d;  ext_we_q <= ewe_d;  ext_word_q <= eword_d;
      ext_addr_q <= eaddr_d;  ext_wdata_q <= ewd_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_SFR_ZERO: assert property (take && !acc_write && acc_word && acc_addr == 8'h00
    && !pri_hit && !sec_hit |=> acc_done_q && acc_rdata_q == 16'h0000)
    else $error("zero register did not read zero");
  AST_PRI_FWD: assert property (take && pri_hit && !acc_word |=> ext_req_q
    && ext_addr_q == $past(win_addr) ##1 !ext_req_q)
    else $error("primary window access not redirected");
  AST_PRI_TOP: assert property (pri_hit |-> acc_addr >= 8'h80)
    else $error("primary window below the top half");
  AST_SEC_MID: assert property (sec_hit |-> acc_addr >= 8'h40 && acc_addr <= 8'h7f)
    else $error("secondary window outside the middle");
  AST_NO_MAC: assert property (HAS_MAC || !sec_hit)
    else $error("secondary window active without mac");
  AST_APART: assert property (!(pri_hit && sec_hit))
    else $error("windows overlap");
  AST_GP_LOW: assert property (acc_addr >= 8'h1a && acc_addr <= 8'h3f
    |-> !pri_hit && !sec_hit)
    else $error("low ram got windowed");
  AST_FWD_WR: assert property (take && (pri_hit || sec_hit) |=> acc_busy_q
    && ext_we_q == $past(acc_write) && ext_word_q == $past(acc_word)
    && ext_wdata_q == $past(acc_wdata))
    else $error("forwarded access lost its qualifiers");
  AST_HOLD: assert property (take && acc_write && (acc_word ? a0 : acc_addr) == 8'h14
    && !pri_hit
    && !sec_hit && !restore_valid |=> hold_protocol_enable == $past(acc_wdata[7]))
    else $error("hold enable did not follow the write");
  AST_WORD_ONLY: assert property (take && acc_write && !acc_word && a0 == 8'h0c
    && !pri_hit && !sec_hit |=> mem_q[8'h0c] == $past(mem_q[8'h0c]))
    else $error("byte write reached accumulator word");
  AST_LOCAL: assert property (take && !pri_hit && !sec_hit |=> acc_done_q && !ext_req_q)
    else $error("uncovered access left the local file");
  COV_BOTH: cover property (pri_on && sec_on);
  COV_FWD:  cover property (ext_req_q ##[1:8] ext_ack);
  COV_POP:  cover property (restore_valid);
endmodule

// [src/rfw_pkg.sv]
// constants, encodings and states of the lower register file windowing and stack block
// assumes one core clock and direct byte addresses 00h-ffh from the cpu datapath
package rfw_pkg;
  localparam logic [7:0]  ADR_ONES     = 8'h02;
  localparam logic [7:0]  ADR_FIRST_RW = 8'h04;
  localparam logic [7:0]  ADR_ACCUMULATOR_STATUS = 8'h0b;
  localparam logic [7:0]  ADR_ACC_W0   = 8'h0c;
  localparam logic [7:0]  ADR_ACC_W1   = 8'h0e;
  localparam logic [7:0]  ADR_INT_FLH  = 8'h12;
  localparam logic [7:0]  ADR_INT_ENH  = 8'h13;
  localparam logic [7:0]  ADR_WSEL_P   = 8'h14;
  localparam logic [7:0]  ADR_WSEL_S   = 8'h15;
  localparam logic [7:0]  ADR_SFR_LAST = 8'h17;
  localparam logic [7:0]  ADR_SP_LO    = 8'h18;
  localparam logic [7:0]  ADR_SP_HI    = 8'h19;
  localparam logic [7:0]  ADR_GP_FIRST = 8'h1a;
  localparam logic [7:0]  ADR_GP_LAST  = 8'h3f;
  localparam logic [7:0]  ADR_INT_ENL  = 8'h08;
  localparam logic [7:0]  ADR_INT_FLL  = 8'h09;
  localparam logic [7:0]  ADR_PTS_LAST = 8'h07;
  localparam logic [7:0]  PRI_TOP      = 8'hff;
  localparam logic [7:0]  SEC_TOP      = 8'h7f;
  localparam logic [7:0]  SEC_END      = 8'h80;
  localparam logic [7:0]  WSEL_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_ONES    = 8'hff;
  localparam int unsigned HOLD_BIT     = 7;
  localparam logic [6:0]  CODE_32_MIN  = 7'h40;
  localparam logic [6:0]  CODE_64_MIN  = 7'h20;
  localparam logic [6:0]  CODE_128_MIN = 7'h10;
  localparam logic [7:0]  SIZE_32      = 8'h20;
  localparam logic [7:0]  SIZE_64      = 8'h40;
  localparam logic [7:0]  SIZE_128     = 8'h80;
  localparam logic [15:0] UPPER_BASE   = 16'h0100;
  localparam logic [15:0] UPPER_SPAN   = 16'h0300;
  localparam logic [15:0] PERIPH_BASE  = 16'h1c00;
  localparam logic [15:0] ENTRY_64K    = 16'h0002;
  localparam logic [15:0] ENTRY_1M     = 16'h0004;
  localparam logic [15:0] ENTRY_WORD   = 16'h0002;
  localparam logic [15:0] SP_RESET     = 16'h0000;
  typedef enum logic [1:0] {ACC_IDLE = 2'b01, ACC_WAIT = 2'b10} acc_state_t;
  typedef enum logic [1:0] {STK_IDLE = 2'b01, STK_BUSY = 2'b10} stk_state_t;
  typedef enum logic [3:0] {
    OP_CALL = 4'b0001, OP_RET = 4'b0010, OP_PUSH = 4'b0100, OP_POP = 4'b1000
  } stk_op_t;
endpackage

// [src/stack_unit.sv]
// stack pointer and call, return, push-all and pop-all sequencer
// assumes one stack request at a time and a memory port that answers with stk_ack
`timescale 1ns/1ps
module stack_unit (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mode_1m,
  input  wire logic        call_req,
  input  wire logic [19:0] pc_in,
  input  wire logic        ret_req,
  input  wire logic        push_all_req,
  input  wire logic        pop_all_req,
  input  wire logic [15:0] push_word,
  input  wire logic [1:0]  sp_we,
  input  wire logic [15:0] sp_wdata,
  input  wire logic        stk_ack,
  input  wire logic [31:0] stk_rdata,
  output logic [15:0]      sp_q,
  output logic             stk_busy_q,
  output logic             stk_req_q,
  output logic             stk_we_q,
  output logic             stk_wide_q,
  output logic [15:0]      stk_addr_q,
  output logic [31:0]      stk_wdata_q,
  output logic [19:0]      pc_out_q,
  output logic             pc_valid_q,
  output logic             restore_valid_q,
  output logic [15:0]      restore_word_q
);
  rfw_pkg::stk_state_t st_q, st_d;
  rfw_pkg::stk_op_t    op_q, op_d;
  logic [15:0] sp_d, addr_d, entry, ret_entry;
  logic [31:0] wdata_d;
  logic [19:0] pc_d;
  logic [15:0] rw_d;
  logic        req_d, we_d, wide_d, pcv_d, rv_d;

  assign entry     = mode_1m ? rfw_pkg::ENTRY_1M : rfw_pkg::ENTRY_64K;
  assign ret_entry = stk_wide_q ? rfw_pkg::ENTRY_1M : rfw_pkg::ENTRY_64K;

  // sequencer next state
  always_comb begin
    st_d = st_q;  op_d = op_q;  sp_d = sp_q;  addr_d = stk_addr_q;
    wdata_d = stk_wdata_q;  we_d = stk_we_q;  wide_d = stk_wide_q;
    pc_d = pc_out_q;  rw_d = restore_word_q;
    req_d = 1'b0;  pcv_d = 1'b0;  rv_d = 1'b0;
    case (st_q)
      rfw_pkg::STK_IDLE: begin
        if (call_req) begin
          sp_d = sp_q - entry;  addr_d = sp_q - entry;
          wdata_d = {12'h000, pc_in};
          we_d = 1'b1;  wide_d = mode_1m;  op_d = rfw_pkg::OP_CALL;
        end else if (ret_req) begin
          addr_d = sp_q;  we_d = 1'b0;  wide_d = mode_1m;  op_d = rfw_pkg::OP_RET;
        end else if (push_all_req) begin
          sp_d = sp_q - rfw_pkg::ENTRY_WORD;  addr_d = sp_q - rfw_pkg::ENTRY_WORD;
          wdata_d = {16'h0000, push_word};
          we_d = 1'b1;  wide_d = 1'b0;  op_d = rfw_pkg::OP_PUSH;
        end else if (pop_all_req) begin
          addr_d = sp_q;  we_d = 1'b0;  wide_d = 1'b0;  op_d = rfw_pkg::OP_POP;
        end else begin
          // cpu writes to the pointer bytes
          if (sp_we[0]) sp_d[7:0] = sp_wdata[7:0];
          if (sp_we[1]) sp_d[15:8] = sp_wdata[15:8];
        end
        if (call_req || ret_req || push_all_req || pop_all_req) begin
          req_d = 1'b1;
          st_d  = rfw_pkg::STK_BUSY;
        end
      end
      rfw_pkg::STK_BUSY: begin
        if (stk_ack) begin
          st_d = rfw_pkg::STK_IDLE;
          if (op_q == rfw_pkg::OP_RET) begin
            pc_d  = stk_wide_q ? stk_rdata[19:0] : {4'h0, stk_rdata[15:0]};
            pcv_d = 1'b1;
            sp_d  = sp_q + ret_entry;
          end else if (op_q == rfw_pkg::OP_POP) begin
            rw_d = stk_rdata[15:0];
            rv_d = 1'b1;
            sp_d = sp_q + rfw_pkg::ENTRY_WORD;
          end
        end
      end
      default: st_d = rfw_pkg::STK_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= rfw_pkg::STK_IDLE;  op_q <= rfw_pkg::OP_CALL;  sp_q <= rfw_pkg::SP_RESET;
      stk_addr_q <= 16'h0000;  stk_wdata_q <= 32'h0000_0000;  stk_we_q <= 1'b0;
      stk_wide_q <= 1'b0;  stk_req_q <= 1'b0;  stk_busy_q <= 1'b0;
      pc_out_q <= 20'h0_0000;  pc_valid_q <= 1'b0;
      restore_word_q <= 16'h0000;  restore_valid_q <= 1'b0;
    end else begin
      st_q <= st_d;  op_q <= op_d;  sp_q <= sp_d;
      stk_addr_q <= addr_d;  stk_wdata_q <= wdata_d;  stk_we_q <= we_d;
      stk_wide_q <= wide_d;  stk_req_q <= req_d;  stk_busy_q <= (st_d == rfw_pkg::STK_BUSY);
      pc_out_q <= pc_d;  pc_valid_q <= pcv_d;
      restore_word_q <= rw_d;  restore_valid_q <= rv_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_CALL_DEC: assert property (st_q == rfw_pkg::STK_IDLE && call_req |=>
    sp_q == $past(sp_q) - (mode_1m ? rfw_pkg::ENTRY_1M : rfw_pkg::ENTRY_64K)
    && stk_addr_q == sp_q && stk_we_q && stk_req_q)
    else $error("call did not predecrement the stack pointer");
  AST_CALL_PC: assert property (st_q == rfw_pkg::STK_IDLE && call_req |=>
    stk_wdata_q[19:0] == $past(pc_in))
    else $error("call did not write the program counter");
  AST_RET_LOAD: assert property (st_q == rfw_pkg::STK_BUSY && op_q == rfw_pkg::OP_RET
    && stk_ack && stk_wide_q |=> pc_valid_q && pc_out_q == $past(stk_rdata[19:0]))
    else $error("return did not load the top entry");
  AST_RET_INC: assert property (st_q == rfw_pkg::STK_BUSY && op_q == rfw_pkg::OP_RET
    && stk_ack |=> sp_q == $past(sp_q) + $past(ret_entry))
    else $error("return did not postincrement the stack pointer");
  AST_PUSH_SEL: assert property (st_q == rfw_pkg::STK_IDLE && !call_req && !ret_req
    && push_all_req |=> stk_wdata_q[15:0] == $past(push_word) ##1 !stk_req_q)
    else $error("push all lost the select word");
  COV_CALL: cover property (call_req && st_q == rfw_pkg::STK_IDLE ##[1:8] stk_ack);
  COV_RET:  cover property (pc_valid_q);
endmodule

// [src/window_decode.sv]
// window select code decoder: size and base address in higher memory
// assumes a registered select byte at its input; purely combinational
`timescale 1ns/1ps
module window_decode #(
  parameter bit ALLOW_128 = 1'b1
) (
  input  wire logic [6:0]  code,
  output logic             win_on,
  output logic [7:0]       win_size,
  output logic [15:0]      win_base
);
  logic [15:0] seg;

  always_comb begin
    win_on   = 1'b0;
    win_size = 8'h00;
    seg      = 16'h0000;
    win_base = 16'h0000;
    if (code >= rfw_pkg::CODE_32_MIN) begin
      win_on   = 1'b1;
      win_size = rfw_pkg::SIZE_32;
      seg      = 16'(code[5:0]) << 5;
    end else if (code >= rfw_pkg::CODE_64_MIN) begin
      win_on   = 1'b1;
      win_size = rfw_pkg::SIZE_64;
      seg      = 16'(code[4:0]) << 6;
    end else if (ALLOW_128 && code >= rfw_pkg::CODE_128_MIN) begin
      win_on   = 1'b1;
      win_size = rfw_pkg::SIZE_128;
      seg      = 16'(code[3:0]) << 7;
    end
    // low segments land in the upper file, the rest in peripheral space
    if (seg < rfw_pkg::UPPER_SPAN) begin
      win_base = rfw_pkg::UPPER_BASE + seg;
    end else begin
      win_base = rfw_pkg::PERIPH_BASE + (seg - rfw_pkg::UPPER_SPAN);
    end
  end
endmodule
